//--- hw/hpb_pkg.sv
// package of constants shared by both ends of the host parallel bus port
package hpb_pkg;
    // bus geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int NUM_REGS = 8;
    localparam int NUM_AXES = 4;
    // register reset value
    localparam logic [15:0] REG_RST = 16'h0000;
    // reset low must be seen on more than this many input clocks
    localparam int RESET_MIN_CYCLES = 4;
    // external interpolation pulse low time, more than this many clocks
    localparam int INTERP_LOW_CYCLES = 4;
    // busy window after a command write, in input clocks (one to four)
    localparam int BUSY_CYCLES = 4;
    // nominal reference clock for rate values, in MHz
    localparam int REF_CLOCK_MHZ = 16;
    // clock rate of this implementation, in MHz
    localparam int CLOCK_MHZ = 40;
    // index of the command register
    localparam logic [2:0] CMD_REG = 3'h0;
    // host strobe widths in clocks
    localparam int HOST_STROBE_CYCLES = 4;
    localparam int HOST_SETUP_CYCLES = 2;
    // bus sequencer states of the host end
    typedef enum logic [2:0] {
        HPB_IDLE,
        HPB_SETUP,
        HPB_STROBE,
        HPB_HOLD,
        HPB_RECOVER
    } hpb_host_state_t;
endpackage

//--- hw/hpb_if.sv
// pin bundle between the host end and the device end
`timescale 1ns/100ps
interface hpb_if;
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [3:0] addr;
    logic bus_width_sel;
    logic hw_reset_low;
    logic ext_interp_pulse_n;
    // data bus as drive values and enables of both ends
    logic [15:0] data_from_host;
    logic data_host_oe;
    logic [15:0] data_from_dev;
    logic data_dev_oe;
    // device outputs
    logic cmd_busy_n;
    logic irq_out_n;
    logic irq_oe;
    logic sys_clock_out;

    modport device (
        input chip_select_n, read_strobe_n, write_strobe_n, addr,
        input bus_width_sel, hw_reset_low, ext_interp_pulse_n,
        input data_from_host, data_host_oe,
        output data_from_dev, data_dev_oe,
        output cmd_busy_n, irq_out_n, irq_oe, sys_clock_out
    );
    modport host (
        output chip_select_n, read_strobe_n, write_strobe_n, addr,
        output bus_width_sel, hw_reset_low, ext_interp_pulse_n,
        output data_from_host, data_host_oe,
        input data_from_dev, data_dev_oe,
        input cmd_busy_n, irq_out_n, irq_oe, sys_clock_out
    );
endinterface

//--- hw/hpb_device.sv
// device end: register port, reset, interpolation pulse, busy and irq pins
`timescale 1ns/100ps

module hpb_device #(
    parameter int NUM_REGS = hpb_pkg::NUM_REGS,
    parameter int NUM_AXES = hpb_pkg::NUM_AXES
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // pins
    hpb_if.device bus,
    // user side: registers, interpolation and interrupt causes
    output logic [NUM_REGS*16-1:0] o_write_regs,
    input wire logic [NUM_REGS*16-1:0] i_read_regs,
    output logic o_cmd_strobe,
    input wire logic [NUM_AXES-1:0] i_interp_axes,
    output logic [NUM_AXES-1:0] o_axis_step,
    input wire logic [7:0] i_irq_cause,
    input wire logic [7:0] i_irq_enable,
    output logic o_in_reset,
    output logic [15:0] o_rate_scale
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    // two stage sync
    logic [5:0] sync1, sync2, next_sync1, next_sync2;
    logic [15:0] data_s1, data_s2;
    logic [3:0] addr_s1, addr_s2;
    logic cs_n, rd_n, wr_n, pulse_n, rst_low, width16;

    always_comb begin
        next_sync1 = {bus.bus_width_sel, bus.hw_reset_low,
                      bus.ext_interp_pulse_n,
                      bus.write_strobe_n, bus.read_strobe_n,
                      bus.chip_select_n};
        next_sync2 = sync1;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1 <= 6'h3f;
            sync2 <= 6'h3f;
            data_s1 <= 16'h0000;
            data_s2 <= 16'h0000;
            addr_s1 <= 4'h0;
            addr_s2 <= 4'h0;
        end else if (i_clk_en) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            data_s1 <= bus.data_from_host;
            data_s2 <= data_s1;
            addr_s1 <= bus.addr;
            addr_s2 <= addr_s1;
        end
    end

    assign cs_n = sync2[0];
    assign rd_n = sync2[1];
    assign wr_n = sync2[2];
    assign pulse_n = sync2[3];
    assign rst_low = sync2[4];
    // width select is a pin too; the host passes i_width16 straight through, unlatched
    assign width16 = sync2[5];

    // ------------------------------------------------------------
    // reset counter and interpolation filter
    // ------------------------------------------------------------
    logic [2:0] rst_cnt, next_rst_cnt;
    logic in_reset, next_in_reset;
    logic [2:0] filt, next_filt;
    logic pulse_f, next_pulse_f;
    logic [NUM_AXES-1:0] step, next_step;

    always_comb begin
        next_rst_cnt = rst_low ? 3'h0 :
            (rst_cnt == 3'(hpb_pkg::RESET_MIN_CYCLES)) ? rst_cnt :
            rst_cnt + 3'h1;
        next_in_reset = (!rst_low &&
            rst_cnt == 3'(hpb_pkg::RESET_MIN_CYCLES)) ? 1'b1 :
            (rst_low ? 1'b0 : in_reset);
        next_filt = filt;
        if (!pulse_n && filt != 3'h0)
            next_filt = filt - 3'h1;
        else if (pulse_n && filt != 3'(hpb_pkg::INTERP_LOW_CYCLES))
            next_filt = filt + 3'h1;
        next_pulse_f = (filt == 3'h0) ? 1'b0 :
            (filt == 3'(hpb_pkg::INTERP_LOW_CYCLES)) ? 1'b1 : pulse_f;
        next_step = (pulse_f && !next_pulse_f && !in_reset) ?
            i_interp_axes : '0;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_cnt <= 3'h0;
            in_reset <= 1'b0;
            filt <= 3'(hpb_pkg::INTERP_LOW_CYCLES);
            pulse_f <= 1'b1;
            step <= '0;
        end else if (i_clk_en) begin
            rst_cnt <= next_rst_cnt;
            in_reset <= next_in_reset;
            filt <= next_filt;
            pulse_f <= next_pulse_f;
            step <= next_step;
        end
    end

    // ------------------------------------------------------------
    // register writes, busy window, half rate clock
    // ------------------------------------------------------------
    logic [15:0] regs [NUM_REGS];
    logic [15:0] next_regs [NUM_REGS];
    logic wr_d, next_wr_d;
    logic [2:0] busy_cnt, next_busy_cnt;
    logic cmd, next_cmd;
    logic half, next_half;
    logic [2:0] idx;
    logic hi_byte;
    logic wr_rise;

    assign idx = width16 ? addr_s2[2:0] : {addr_s2[3], addr_s2[2:1]};
    // odd byte location is high byte
    assign hi_byte = !width16 && addr_s2[0];
    assign wr_rise = wr_n && !wr_d && !cs_n;

    always_comb begin
        for (int k = 0; k < NUM_REGS; k++)
            next_regs[k] = in_reset ? hpb_pkg::REG_RST : regs[k];
        next_cmd = 1'b0;
        // command writes blocked while busy
        if (wr_rise && !in_reset &&
            !(idx == hpb_pkg::CMD_REG && busy_cnt != 3'h0)) begin
            if (width16)
                next_regs[idx] = data_s2;
            else if (hi_byte)
                next_regs[idx][15:8] = data_s2[7:0];
            else
                next_regs[idx][7:0] = data_s2[7:0];
            next_cmd = (idx == hpb_pkg::CMD_REG) && (width16 || hi_byte);
        end
        next_wr_d = wr_n;
        if (next_cmd)
            next_busy_cnt = 3'(hpb_pkg::BUSY_CYCLES);
        else if (busy_cnt != 3'h0)
            next_busy_cnt = busy_cnt - 3'h1;
        else
            next_busy_cnt = 3'h0;
        next_half = (in_reset || next_in_reset) ? 1'b0 : !half;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int k = 0; k < NUM_REGS; k++)
                regs[k] <= hpb_pkg::REG_RST;
            wr_d <= 1'b1;
            busy_cnt <= 3'h0;
            cmd <= 1'b0;
            half <= 1'b0;
        end else if (i_clk_en) begin
            regs <= next_regs;
            wr_d <= next_wr_d;
            busy_cnt <= next_busy_cnt;
            cmd <= next_cmd;
            half <= next_half;
        end
    end

    // ------------------------------------------------------------
    // read path and outputs
    // ------------------------------------------------------------
    logic [15:0] rd_word;
    logic [15:0] rd_data, next_rd_data;

    // flatten registers to the user side
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_flat
            assign o_write_regs[g*16 +: 16] = regs[g];
        end
    endgenerate

    always_comb begin
        rd_word = i_read_regs[idx*16 +: 16];
        // word or byte on low lines
        if (width16)
            next_rd_data = rd_word;
        else
            next_rd_data = {8'h00, hi_byte ? rd_word[15:8] : rd_word[7:0]};
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst)
            rd_data <= 16'h0000;
        else if (i_clk_en)
            rd_data <= next_rd_data;
    end

    // drive only with select and read low
    assign bus.data_dev_oe = !bus.chip_select_n && !bus.read_strobe_n;
    assign bus.data_from_dev = rd_data;
    assign bus.cmd_busy_n = (busy_cnt == 3'h0);
    // irq low while pending outside pin reset, otherwise released
    assign bus.irq_oe = |(i_irq_cause & i_irq_enable) && !in_reset;
    assign bus.irq_out_n = 1'b0;
    assign bus.sys_clock_out = half;
    assign o_cmd_strobe = cmd;
    assign o_axis_step = step;
    assign o_in_reset = in_reset;
    // rate scale, reference over actual clock in 8.8 form
    assign o_rate_scale = 16'((hpb_pkg::REF_CLOCK_MHZ * 256) /
        hpb_pkg::CLOCK_MHZ);
endmodule

//--- hw/hpb_host.sv
// host end: drives strobes, address and data for single accesses
`timescale 1ns/100ps
module hpb_host (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // pins
    hpb_if.host bus,
    // user side access request
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_width16,
    input wire logic i_dev_reset,
    input wire logic i_interp,
    output logic o_ready,
    output logic o_done,
    output logic [15:0] o_rdata
);
    logic [2:0] cnt, next_cnt;
    logic wr, next_wr;
    logic [3:0] addr, next_addr;
    logic [15:0] wdata, next_wdata, rdata, next_rdata;
    logic done, next_done;
    logic rst_pin, next_rst_pin;
    logic [2:0] ip_cnt, next_ip_cnt;
    hpb_pkg::hpb_host_state_t st, next_st;

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_wr = wr;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_done = 1'b0;
        // reset pin held low while requested
        next_rst_pin = !i_dev_reset;
        // hold pulse low beyond the minimum
        if (i_interp && ip_cnt == 3'h0)
            next_ip_cnt = 3'(hpb_pkg::INTERP_LOW_CYCLES + 2);
        else
            next_ip_cnt = (ip_cnt != 3'h0) ? ip_cnt - 3'h1 : 3'h0;
        unique case (st)
            hpb_pkg::HPB_IDLE: begin
                if (i_req) begin
                    next_wr = i_write;
                    next_addr = i_addr;
                    next_wdata = i_wdata;
                    next_cnt = 3'(hpb_pkg::HOST_SETUP_CYCLES);
                    next_st = hpb_pkg::HPB_SETUP;
                end
            end
            hpb_pkg::HPB_SETUP: begin
                next_cnt = cnt - 3'h1;
                if (cnt == 3'h1) begin
                    next_cnt = 3'(hpb_pkg::HOST_STROBE_CYCLES);
                    next_st = hpb_pkg::HPB_STROBE;
                end
            end
            hpb_pkg::HPB_STROBE: begin
                next_cnt = cnt - 3'h1;
                if (cnt == 3'h1) begin
                    // sample late, device data is registered
                    next_rdata = bus.data_from_dev;
                    next_cnt = 3'(hpb_pkg::HOST_SETUP_CYCLES);
                    next_st = hpb_pkg::HPB_HOLD;
                end
            end
            hpb_pkg::HPB_HOLD: begin
                next_cnt = cnt - 3'h1;
                if (cnt == 3'h1) begin
                    next_cnt = 3'(hpb_pkg::HOST_SETUP_CYCLES);
                    next_st = hpb_pkg::HPB_RECOVER;
                end
            end
            hpb_pkg::HPB_RECOVER: begin
                next_cnt = cnt - 3'h1;
                if (cnt == 3'h1) begin
                    next_done = 1'b1;
                    next_st = hpb_pkg::HPB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= hpb_pkg::HPB_IDLE;
            cnt <= 3'h0;
            wr <= 1'b0;
            addr <= 4'h0;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
            done <= 1'b0;
            rst_pin <= 1'b0;
            ip_cnt <= 3'h0;
        end else if (i_clk_en) begin
            st <= next_st;
            cnt <= next_cnt;
            wr <= next_wr;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            done <= next_done;
            rst_pin <= next_rst_pin;
            ip_cnt <= next_ip_cnt;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // select and address held around strobe
    assign bus.chip_select_n = (st == hpb_pkg::HPB_IDLE);
    assign bus.addr = addr;
    assign bus.write_strobe_n = !(wr && st == hpb_pkg::HPB_STROBE);
    assign bus.read_strobe_n = !(!wr && st == hpb_pkg::HPB_STROBE);
    assign bus.data_from_host = wdata;
    assign bus.data_host_oe = wr && (st != hpb_pkg::HPB_IDLE);
    assign bus.bus_width_sel = i_width16;
    assign bus.hw_reset_low = rst_pin;
    assign bus.ext_interp_pulse_n = (ip_cnt == 3'h0);
    assign o_ready = (st == hpb_pkg::HPB_IDLE);
    assign o_done = done;
    assign o_rdata = rdata;
endmodule

//--- bench/hpb_assertions.sv
// pin level checks between the host end and the device end
`timescale 1ns/100ps
module hpb_assertions (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // pins seen on the bundle
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [3:0] addr,
    input wire logic bus_width_sel,
    input wire logic hw_reset_low,
    input wire logic ext_interp_pulse_n,
    input wire logic [15:0] data_from_host,
    input wire logic data_host_oe,
    input wire logic data_dev_oe,
    input wire logic cmd_busy_n,
    input wire logic irq_out_n,
    input wire logic irq_oe,
    input wire logic sys_clock_out
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    a_data_drive_gate: assert property (
        data_dev_oe == (!chip_select_n && !read_strobe_n))
        else $error("device drives data outside a read");
    a_select_for_strobe: assert property (
        (!write_strobe_n || !read_strobe_n) |-> !chip_select_n)
        else $error("strobe without chip select");
    a_addr_held_write: assert property (
        (!write_strobe_n && !$past(write_strobe_n)) |-> $stable(addr))
        else $error("address moved during write strobe");
    a_write_data_held: assert property (
        $rose(write_strobe_n) |-> (data_host_oe && $stable(data_from_host))[*2])
        else $error("write data not held past strobe rise");
    a_busy_after_cmd: assert property (
        ($rose(write_strobe_n) && bus_width_sel && addr[2:0] == 3'h0)
        |-> ##[1:8] !cmd_busy_n)
        else $error("no busy after command write");
    // pin reset does not touch busy; the check still only judges with the pin released
    a_busy_bounded: assert property (
        ($fell(cmd_busy_n) && hw_reset_low) |-> ##[1:4] cmd_busy_n)
        else $error("busy held too long");
    a_irq_pull_low: assert property (
        irq_oe |-> !irq_out_n)
        else $error("irq enabled but not low");
    a_sclk_toggles: assert property (
        (hw_reset_low && $past(hw_reset_low, 8))
        |-> sys_clock_out != $past(sys_clock_out))
        else $error("system clock out not at half rate");
    a_sclk_held: assert property (
        (!hw_reset_low [*8] ##1 !hw_reset_low [*3]) |-> !sys_clock_out)
        else $error("system clock out runs in reset");
    a_interp_width: assert property (
        $fell(ext_interp_pulse_n) |-> !ext_interp_pulse_n [*5])
        else $error("interpolation pulse too short");
endmodule

//--- bench/tb.sv
// self-checking bench joining host end and device end
`timescale 1ns/100ps
module tb;
    // ----
    // signals
    // ----
    logic i_clock, i_sys_rst, i_clk_en, i_req, i_write, i_width16;
    logic i_dev_reset, i_interp, o_ready, o_done, o_cmd_strobe, o_in_reset;
    logic [3:0] i_addr, i_interp_axes, o_axis_step, step_or;
    logic [15:0] i_wdata, o_rdata, o_rate_scale, rd;
    logic [hpb_pkg::NUM_REGS*16-1:0] o_write_regs, i_read_regs;
    logic [7:0] i_irq_cause, i_irq_enable;
    logic in_reset_seen, sclk_in_reset;
    int n_errors = 0, checked = 0, cycles = 0;
    int n_cmd = 0, busy_low = 0, step_cycles = 0;

    hpb_if bus();
    hpb_host u_hpb_host (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en), .bus(bus), .i_req(i_req), .i_write(i_write),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_width16(i_width16),
        .i_dev_reset(i_dev_reset), .i_interp(i_interp), .o_ready(o_ready),
        .o_done(o_done), .o_rdata(o_rdata));
    hpb_device u_hpb_device (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en), .bus(bus), .o_write_regs(o_write_regs),
        .i_read_regs(i_read_regs), .o_cmd_strobe(o_cmd_strobe),
        .i_interp_axes(i_interp_axes), .o_axis_step(o_axis_step),
        .i_irq_cause(i_irq_cause), .i_irq_enable(i_irq_enable),
        .o_in_reset(o_in_reset), .o_rate_scale(o_rate_scale));
    hpb_assertions u_hpb_assertions (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .chip_select_n(bus.chip_select_n),
        .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .addr(bus.addr),
        .bus_width_sel(bus.bus_width_sel), .hw_reset_low(bus.hw_reset_low),
        .ext_interp_pulse_n(bus.ext_interp_pulse_n),
        .data_from_host(bus.data_from_host),
        .data_host_oe(bus.data_host_oe), .data_dev_oe(bus.data_dev_oe),
        .cmd_busy_n(bus.cmd_busy_n), .irq_out_n(bus.irq_out_n),
        .irq_oe(bus.irq_oe), .sys_clock_out(bus.sys_clock_out));

    // 40 MHz clock
    always #12.5 i_clock = ~i_clock;

    // event monitors; the cycle ceiling is far above the run of ~250 cycles
    always @(negedge i_clock) begin
        cycles++;
        if (o_cmd_strobe === 1'b1) n_cmd++;
        if (bus.cmd_busy_n === 1'b0) busy_low++;
        if (o_axis_step !== 4'h0) step_cycles++;
        step_or = step_or | o_axis_step;
        if (o_in_reset === 1'b1) in_reset_seen = 1'b1;
        if (o_in_reset === 1'b1 && bus.sys_clock_out !== 1'b0)
            sclk_in_reset = 1'b1;
        if (cycles == 4000) begin
            n_errors++;
            $display("ERROR at %0t: run hung", $time);
            close_out();
        end
    end

    // ----
    // compare and bus tasks
    // ----
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // one access; the request is held across exactly one taking edge
    task automatic access(input logic wr, input logic [3:0] a,
            input logic [15:0] d, input logic w16);
        int k;
        k = 0;
        while (o_ready !== 1'b1 && k < 40) begin
            @(negedge i_clock);
            k++;
        end
        i_req = 1'b1;
        i_write = wr;
        i_addr = a;
        i_wdata = d;
        i_width16 = w16;
        @(negedge i_clock);
        i_req = 1'b0;
        k = 0;
        while (o_done !== 1'b1 && k < 40) begin
            @(negedge i_clock);
            k++;
        end
        check_flag(o_done, 1'b1);
        rd = o_rdata;
        @(negedge i_clock);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_word();
        access(1'b1, 4'h3, 16'hc35a, 1'b1);
        check_val(o_write_regs[3*16+:16], 16'hc35a);
        access(1'b1, 4'hb, 16'h1234, 1'b1);
        check_val(o_write_regs[3*16+:16], 16'h1234);
    endtask

    task automatic t_cmd();
        n_cmd = 0;
        busy_low = 0;
        access(1'b1, 4'h0, 16'h0027, 1'b1);
        repeat (6) @(negedge i_clock);
        check_val(16'(n_cmd), 16'h0001);
        check_flag(busy_low >= 1 && busy_low <= 4, 1'b1);
        check_val(o_write_regs[15:0], 16'h0027);
    endtask

    task automatic t_read();
        i_read_regs[5*16+:16] = 16'h9e61;
        access(1'b0, 4'h5, 16'h0000, 1'b1);
        check_val(rd, 16'h9e61);
        access(1'b0, 4'hd, 16'h0000, 1'b1);
        check_val(rd, 16'h9e61);
        check_flag(bus.data_dev_oe, 1'b0);
    endtask

    // byte lanes: high byte at the odd location
    task automatic t_byte();
        i_read_regs[4*16+:16] = 16'hd2b7;
        access(1'b1, 4'h9, 16'h00a5, 1'b0);
        access(1'b1, 4'h8, 16'h003c, 1'b0);
        check_val(o_write_regs[4*16+:16], 16'ha53c);
        access(1'b0, 4'h9, 16'h0000, 1'b0);
        check_val(rd, 16'h00d2);
        access(1'b0, 4'h8, 16'h0000, 1'b0);
        check_val(rd, 16'h00b7);
    endtask

    task automatic t_interp(input logic [3:0] axes);
        step_or = 4'h0;
        step_cycles = 0;
        i_interp_axes = axes;
        i_interp = 1'b1;
        @(negedge i_clock);
        i_interp = 1'b0;
        repeat (20) @(negedge i_clock);
        check_val({12'h000, step_or}, {12'h000, axes});
        check_val(16'(step_cycles), 16'h0001);
    endtask

    task automatic t_irq();
        i_irq_cause = 8'h24;
        i_irq_enable = 8'h03;
        repeat (4) @(negedge i_clock);
        check_flag(bus.irq_oe, 1'b0);
        i_irq_enable = 8'h20;
        repeat (4) @(negedge i_clock);
        check_flag(bus.irq_oe, 1'b1);
        check_flag(bus.irq_out_n, 1'b0);
        i_irq_cause = 8'h04;
        repeat (4) @(negedge i_clock);
        check_flag(bus.irq_oe, 1'b0);
    endtask

    // a pulse of three clocks is too short, fourteen is enough
    task automatic t_pin_reset();
        logic s0;
        in_reset_seen = 1'b0;
        i_dev_reset = 1'b1;
        repeat (3) @(negedge i_clock);
        i_dev_reset = 1'b0;
        repeat (12) @(negedge i_clock);
        check_flag(in_reset_seen, 1'b0);
        check_val(o_write_regs[3*16+:16], 16'h1234);
        sclk_in_reset = 1'b0;
        i_dev_reset = 1'b1;
        repeat (14) @(negedge i_clock);
        check_flag(o_in_reset, 1'b1);
        for (int k = 0; k < hpb_pkg::NUM_REGS; k++)
            check_val(o_write_regs[k*16+:16], hpb_pkg::REG_RST);
        i_dev_reset = 1'b0;
        repeat (12) @(negedge i_clock);
        check_flag(sclk_in_reset, 1'b0);
        s0 = bus.sys_clock_out;
        @(negedge i_clock);
        check_flag(bus.sys_clock_out, ~s0);
    endtask

    task automatic close_out();
        $display("checks %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // main sequence
    initial begin
        i_clock = 1'b0;
        i_sys_rst = 1'b1;
        i_clk_en = 1'b1;
        {i_req, i_write, i_width16, i_dev_reset, i_interp} = 5'h02;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        i_interp_axes = 4'h0;
        i_read_regs = '0;
        i_irq_cause = 8'h00;
        i_irq_enable = 8'h00;
        repeat (2) @(negedge i_clock);
        i_sys_rst = 1'b0;
        // pin reset after power up, released before the first access
        repeat (14) @(negedge i_clock);
        check_flag(o_in_reset, 1'b1);
        i_dev_reset = 1'b0;
        repeat (20) @(negedge i_clock);
        check_val(o_rate_scale, 16'(hpb_pkg::REF_CLOCK_MHZ * 256
            / hpb_pkg::CLOCK_MHZ));
        t_word();
        t_cmd();
        t_read();
        t_byte();
        t_interp(4'ha);
        t_interp(4'h7);
        t_irq();
        t_pin_reset();
        close_out();
    end
endmodule
